// >>> rtl/adcsq_sequencer.sv
// conversion control of an 8-bit successive-approximation converter:
// start strobe, restart abort, result latch, done flag and read drive
// assumes the comparator is an input on the system clock domain and that
// the bus strobes and the conversion clock arrive asynchronously
//
// What this block does
// - a start pulse during a conversion aborts it and starts afresh
// - an aborted conversion never writes the output latch
// - the done output stays high across an abort and restart
// - the conversion clock is external, taken in on conv_clk_i and sampled
// - the result is 8 bits, one code per span/256, 00 to ff
`timescale 1ns/1ns
module adcsq_sequencer
    import adcsq_pkg::*;
#(
    parameter int unsigned CLK_PER_BIT = CONV_CLK_PER_BIT
)
(
    input  wire logic                clk_sys_i,
    input  wire logic                arst_n_i,
    input  wire logic                chip_sel_n_i,
    input  wire logic                wr_n_i,
    input  wire logic                rd_n_i,
    input  wire logic                conv_clk_i,
    input  wire logic                cmp_high_i,
    output logic [RES_BITS-1:0]      dac_code_o,
    output logic [RES_BITS-1:0]      data_o,
    output logic                     data_oe_n_o,
    output logic                     conversion_done_n_o,
    output logic                     busy_o
);

    ////////////////////////////////////////////////////////////////////////
    // synchronisers for pins; first stage read only by the second
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic [3:0] nxt_sync1;
    logic [3:0] nxt_sync2;
    logic       cs_n_s;
    logic       wr_n_s;
    logic       rd_n_s;
    logic       cclk_s;
    logic       start_arm_ff;
    logic       nxt_start_arm;
    logic       cclk_prev_ff;
    logic       nxt_cclk_prev;
    logic       start_pulse;
    logic       cclk_rise;

    always_comb
    begin
        nxt_sync1 = {conv_clk_i, rd_n_i, wr_n_i, chip_sel_n_i};
        nxt_sync2 = sync1_ff;
    end

    assign cs_n_s = sync2_ff[0];
    assign wr_n_s = sync2_ff[1];
    assign rd_n_s = sync2_ff[2];
    assign cclk_s = sync2_ff[3];

    // start fires when the strobe pair is released, not when asserted
    always_comb
    begin
        nxt_start_arm = ~cs_n_s & ~wr_n_s;
        nxt_cclk_prev = cclk_s;
    end

    assign start_pulse = start_arm_ff & ~(~cs_n_s & ~wr_n_s);
    // the external conversion clock is seen here only once sampled
    assign cclk_rise   = cclk_s & ~cclk_prev_ff;

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sync1_ff     <= 4'hf;
            sync2_ff     <= 4'hf;
            start_arm_ff <= 1'b0;
            // matches the synced reset level, so no false edge after reset
            cclk_prev_ff <= 1'b1;
        end
        else
        begin
            sync1_ff     <= nxt_sync1;
            sync2_ff     <= nxt_sync2;
            start_arm_ff <= nxt_start_arm;
            cclk_prev_ff <= nxt_cclk_prev;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // successive-approximation sequencer
    adcsq_state_type      state_ff;
    adcsq_state_type      nxt_state;
    logic [RES_BITS-1:0]  sar_ff;
    logic [RES_BITS-1:0]  nxt_sar;
    logic [RES_BITS-1:0]  latch_ff;
    logic [RES_BITS-1:0]  nxt_latch;
    logic [3:0]           bit_ff;
    logic [3:0]           nxt_bit;
    logic [7:0]           tick_ff;
    logic [7:0]           nxt_tick;
    logic                 done_n_ff;
    logic                 nxt_done_n;
    logic                 bit_end;

    assign bit_end = cclk_rise && (tick_ff == 8'(CLK_PER_BIT - 1));

    always_comb
    begin
        nxt_state  = state_ff;
        nxt_sar    = sar_ff;
        nxt_latch  = latch_ff;
        nxt_bit    = bit_ff;
        nxt_tick   = tick_ff;
        nxt_done_n = done_n_ff;
        if (start_pulse)
        begin
            // any start resets the sar, abort included; latch left alone
            nxt_state  = ADCSQ_CONV;
            nxt_sar    = 8'h80;
            nxt_bit    = BIT_RST;
            nxt_tick   = 8'h00;
            nxt_done_n = 1'b1;
        end
        else
        begin
            case (state_ff)
                ADCSQ_IDLE:
                begin
                    nxt_state = ADCSQ_IDLE;
                end
                ADCSQ_CONV:
                begin
                    if (cclk_rise)
                    begin
                        nxt_tick = bit_end ? 8'h00 : tick_ff + 8'h01;
                    end
                    if (bit_end)
                    begin
                        // keep the trial bit only if input is above the dac
                        nxt_sar[bit_ff[2:0]] = cmp_high_i;
                        if (bit_ff == 4'h0)
                        begin
                            nxt_state = ADCSQ_DONE;
                        end
                        else
                        begin
                            nxt_sar[bit_ff[2:0] - 3'h1] = 1'b1;
                            nxt_bit = bit_ff - 4'h1;
                        end
                    end
                end
                ADCSQ_DONE:
                begin
                    // only a finished conversion reaches the latch
                    nxt_latch  = sar_ff;
                    nxt_done_n = 1'b0;
                    nxt_state  = ADCSQ_IDLE;
                end
                default:
                begin
                    nxt_state = ADCSQ_IDLE;
                end
            endcase
        end
        // a read, or a start strobe held low, clears done; the strobe clear
        // is what lets a free-running loop release its start again
        if (!cs_n_s && (!rd_n_s || !wr_n_s) && !start_pulse
            && state_ff != ADCSQ_DONE)
        begin
            nxt_done_n = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_ff  <= ADCSQ_IDLE;
            sar_ff    <= RESULT_RST;
            latch_ff  <= RESULT_RST;
            bit_ff    <= BIT_RST;
            tick_ff   <= 8'h00;
            done_n_ff <= 1'b1;
        end
        else
        begin
            state_ff  <= nxt_state;
            sar_ff    <= nxt_sar;
            latch_ff  <= nxt_latch;
            bit_ff    <= nxt_bit;
            tick_ff   <= nxt_tick;
            done_n_ff <= nxt_done_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs; pins are driven only during a selected read
    assign dac_code_o          = sar_ff;
    assign data_o              = latch_ff;
    assign data_oe_n_o         = cs_n_s | rd_n_s;
    assign conversion_done_n_o = done_n_ff;
    assign busy_o              = (state_ff != ADCSQ_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_start;
        start_pulse;
    endsequence

    sequence s_restart;
        (state_ff == ADCSQ_CONV) ##0 start_pulse;
    endsequence

    property p_abort_fresh;
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        s_restart |=> (state_ff == ADCSQ_CONV) && (sar_ff == 8'h80)
            && (bit_ff == BIT_RST);
    endproperty

    a_restart_fresh_conv: assert property (p_abort_fresh)
        else $error("restart did not begin a fresh conversion");

    a_abort_keeps_latch: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        s_restart |=> $stable(latch_ff))
        else $error("aborted conversion changed the latch");

    a_abort_done_high: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        s_start |=> conversion_done_n_o throughout
            (state_ff == ADCSQ_CONV) [*2])
        else $error("done went low during a restarted conversion");

    a_latch_only_done: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        $changed(latch_ff) |-> $past(state_ff) == ADCSQ_DONE)
        else $error("latch written outside completion");

    a_done_loads_latch: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        (state_ff == ADCSQ_DONE) && !start_pulse |=>
            !conversion_done_n_o && (latch_ff == $past(sar_ff)))
        else $error("completion did not load latch and drive done");

    a_drive_on_read: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        !data_oe_n_o |-> ($past(chip_sel_n_i, 2) == 1'b0)
            && ($past(rd_n_i, 2) == 1'b0))
        else $error("data driven without a selected read");

    a_eight_bits_done: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        (state_ff == ADCSQ_CONV) && bit_end && (bit_ff == 4'h0)
            && !start_pulse |=> state_ff == ADCSQ_DONE)
        else $error("conversion did not finish after the last bit");

    a_done_needs_conv: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        $fell(conversion_done_n_o) |-> $past(state_ff) == ADCSQ_DONE)
        else $error("done fell without a completed conversion");

endmodule

// >>> rtl/adcsq_pkg.sv
// constants for the conversion sequencer of an 8-bit successive-approximation
// converter; shared by the design and the bench
package adcsq_pkg;
    localparam int unsigned RES_BITS       = 8;     // result width, span/256
    localparam int unsigned CODE_STEPS     = 256;   // codes over the span
    localparam logic [7:0]  RESULT_RST     = 8'h00; // latch value after reset
    localparam int unsigned CONV_CLK_PER_BIT = 8;   // conversion clocks per bit
    localparam logic [3:0]  BIT_RST        = 4'h7;  // first bit tried (msb)
    typedef enum logic [1:0]
    {
        ADCSQ_IDLE = 2'b00,
        ADCSQ_CONV = 2'b01,
        ADCSQ_DONE = 2'b10
    } adcsq_state_type;
endpackage

// >>> sim/adcsq_host_model.sv
// host bus and analog source facing the conversion sequencer
// assumes one bench process calls its tasks at a time
`timescale 1ns/1ns
module adcsq_host_model
    import adcsq_pkg::*;
(
    input  wire logic                clk_sys_i,
    input  wire logic [RES_BITS-1:0] dac_code_i,
    input  wire logic                done_n_i,
    output logic                     cs_n_o,
    output logic                     wr_n_o,
    output logic                     rd_n_o,
    output logic                     cmp_high_o
);
    logic [RES_BITS-1:0] vin      = 8'h00;
    logic                cs_ff    = 1'b1;
    logic                wr_ff    = 1'b1;
    logic                rd_ff    = 1'b1;
    logic                free_run = 1'b0;
    logic                kick_n   = 1'b1;
    // source sits half a code above vin, so no tie ever decides a bit
    assign cmp_high_o = {vin, 1'b1} > {dac_code_i, 1'b0};
    // free run grounds select and loops done back to start
    assign cs_n_o = free_run ? 1'b0 : cs_ff;
    assign wr_n_o = free_run ? (done_n_i & kick_n) : wr_ff;
    assign rd_n_o = rd_ff;
    // strobes move after an edge and hold n cycles; long holds act as
    // wait states of a fast host
    task automatic bus(input logic cs, wr, rd, input int n);
        @(posedge clk_sys_i);
        cs_ff <= cs;
        wr_ff <= wr;
        rd_ff <= rd;
        repeat (n) @(posedge clk_sys_i);
    endtask
    // one forced low pulse on the shared start and done node
    task automatic kick();
        @(posedge clk_sys_i);
        kick_n <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        kick_n <= 1'b1;
    endtask
endmodule

// >>> sim/test_adcsq_sequencer.sv
// self-checking bench for the conversion sequencer
// assumes the host model drives every strobe and the comparator
`timescale 1ns/1ns
module test_adcsq_sequencer;
    import adcsq_pkg::*;
    logic                clk_sys_i = 1'b0;
    logic                arst_n_i  = 1'b0;
    logic                conv_clk  = 1'b0;
    logic                cs_n, wr_n, rd_n, cmp_high, oe_n, done_n, busy;
    logic [RES_BITS-1:0] dac_code, data, old;
    logic [RES_BITS-1:0] rd_data;
    logic [RES_BITS-1:0] src [16];
    logic [RES_BITS-1:0] mem [16];
    int                  err_count = 0;
    int                  n_compared = 0;
    int                  k;
    always #20 clk_sys_i = ~clk_sys_i;
    // external conversion clock, unrelated in phase to the system clock
    always #50 conv_clk = ~conv_clk;
    adcsq_sequencer #(.CLK_PER_BIT(1)) u_adcsq_sequencer (
        .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .chip_sel_n_i(cs_n),
        .wr_n_i(wr_n), .rd_n_i(rd_n), .conv_clk_i(conv_clk),
        .cmp_high_i(cmp_high), .dac_code_o(dac_code), .data_o(data),
        .data_oe_n_o(oe_n), .conversion_done_n_o(done_n), .busy_o(busy));
    adcsq_host_model u_adcsq_host_model (
        .clk_sys_i(clk_sys_i), .dac_code_i(dac_code), .done_n_i(done_n),
        .cs_n_o(cs_n), .wr_n_o(wr_n), .rd_n_o(rd_n), .cmp_high_o(cmp_high));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] exp_code(input logic [7:0] v);
        return 8'(v % CODE_STEPS);
    endfunction
    task automatic chk_code(input logic [7:0] got, exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t code %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    // bounded wait for the done level
    task automatic wait_done(input logic lvl);
        for (int i = 0; i < 200 && done_n !== lvl; i++) @(negedge clk_sys_i);
        chk_bit(done_n, lvl);
    endtask
    task automatic start();
        u_adcsq_host_model.bus(1'b0, 1'b0, 1'b1, 2);
        u_adcsq_host_model.bus(1'b1, 1'b1, 1'b1, 0);
    endtask
    // stretched read: pins driven only while selected, done then clears
    task automatic read_check(input logic [7:0] exp);
        u_adcsq_host_model.bus(1'b0, 1'b1, 1'b0, 3);
        @(negedge clk_sys_i);
        chk_bit(oe_n, 1'b0);
        chk_code(data, exp);
        rd_data = data;
        u_adcsq_host_model.bus(1'b1, 1'b1, 1'b1, 3);
        @(negedge clk_sys_i);
        chk_bit(oe_n, 1'b1);
        chk_bit(done_n, 1'b1);
    endtask
    task automatic summarize();
        if (err_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        err_count++;
        summarize();
    end
    initial
    begin
        old = 8'($urandom(32'h2786a18c));
        repeat (5) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        @(negedge clk_sys_i);
        chk_code(data, RESULT_RST);
        chk_bit(done_n, 1'b1);
        // full conversions, the two end codes first
        // sixteen results read and stored in sixteen places, as a host does
        for (k = 0; k < 16; k++)
        begin
            src[k] = (k < 2) ? {8{k[0]}} : 8'($urandom);
            @(posedge clk_sys_i);
            u_adcsq_host_model.vin <= src[k];
            start();
            wait_done(1'b0);
            chk_bit(busy, 1'b0);
            chk_code(data, exp_code(src[k]));
            read_check(exp_code(src[k]));
            mem[k] = rd_data;
        end
        for (k = 0; k < 16; k++)
        begin
            chk_code(mem[k], exp_code(src[k]));
        end
        // restart in mid conversion, read while busy sees the old latch
        old = data;
        u_adcsq_host_model.vin <= 8'($urandom);
        start();
        repeat (4) @(posedge clk_sys_i);
        u_adcsq_host_model.vin <= 8'($urandom);
        start();
        read_check(old);
        for (k = 0; k < 12; k++)
        begin
            @(negedge clk_sys_i);
            chk_bit(done_n, 1'b1);
            chk_bit(busy, 1'b1);
        end
        chk_code(data, old);
        wait_done(1'b0);
        chk_code(data, exp_code(u_adcsq_host_model.vin));
        read_check(exp_code(u_adcsq_host_model.vin));
        // free running loop started by one forced pulse
        u_adcsq_host_model.vin <= 8'h3c;
        u_adcsq_host_model.free_run <= 1'b1;
        u_adcsq_host_model.kick();
        for (k = 0; k < 3; k++)
        begin
            wait_done(1'b0);
            chk_code(data, exp_code(8'h3c));
            wait_done(1'b1);
        end
        u_adcsq_host_model.free_run <= 1'b0;
        summarize();
    end
endmodule
